// ---- tpuc_consts.vh ----
// Purpose: constants of the timer contention block
// Assumes: APB with 32-bit data, one word per register
// Notes: offsets are byte addresses
`ifndef TPUC_CONSTS_VH
`define TPUC_CONSTS_VH

// ----------------------------------------
// register byte offsets
// ----------------------------------------
`define TPUC_OFS_CTRL 5'h00
`define TPUC_OFS_STAT 5'h04
`define TPUC_OFS_CNT 5'h08
`define TPUC_OFS_MATCH 5'h0C
`define TPUC_OFS_BUF 5'h10

// ----------------------------------------
// control register fields
// ----------------------------------------
`define TPUC_C_RUN 0
`define TPUC_C_CKS_LO 1
`define TPUC_C_CKS_HI 2
`define TPUC_C_CLR_LO 3
`define TPUC_C_CLR_HI 4
`define TPUC_C_CAPT 5
`define TPUC_C_BUFEN 6
`define TPUC_C_MIE 7
`define TPUC_C_VIE 8
`define TPUC_C_UIE 9
`define TPUC_C_XFEN 10
`define TPUC_C_STOP 11
`define TPUC_C_OE 12
`define TPUC_CTRL_W 13
`define TPUC_CTRL_RST 13'h0000

// ----------------------------------------
// status register fields
// ----------------------------------------
`define TPUC_S_MCF 0
`define TPUC_S_OVF 1
`define TPUC_S_UNF 2
`define TPUC_S_DIR 3

// ----------------------------------------
// clock and clear selections
// ----------------------------------------
`define TPUC_CKS_INT 2'h0
`define TPUC_CKS_RISE 2'h1
`define TPUC_CKS_BOTH 2'h2
`define TPUC_CKS_PHASE 2'h3
`define TPUC_CLR_NONE 2'h0
`define TPUC_CLR_MATCH 2'h1
`define TPUC_CLR_CAPT 2'h2

// ----------------------------------------
// reset values
// ----------------------------------------
`define TPUC_CNT_RST 16'h0000
`define TPUC_MATCH_RST 16'hFFFF
`define TPUC_BUF_RST 16'hFFFF

`endif

// ---- tpuc_edge.v ----
// Purpose: synchronise count clock and capture pins, detect edges
// Assumes: pins are asynchronous to ref_clk
// Notes: all outputs come from flip-flops; tick_q and cap_q are one-cycle pulses, down_q is a level
`timescale 1ns/1ps
`include "tpuc_consts.vh"

module tpuc_edge (
	// clock and reset
	input wire clk,
	input wire rst_n,
	// selection
	input wire [1:0] cks,
	// pins
	input wire pin_a,
	input wire pin_b,
	input wire pin_cap,
	// events
	output reg tick_q,
	output reg down_q,
	output reg cap_q
);

// ----------------------------------------
// two-stage synchronisers
// ----------------------------------------
reg [2:0] s1_q;
reg [2:0] s2_q;
reg [2:0] s3_q;
wire a_now = s2_q[0];
wire b_now = s2_q[1];
wire a_rise = s2_q[0] & ~s3_q[0];
wire a_fall = ~s2_q[0] & s3_q[0];
wire a_chg = s2_q[0] ^ s3_q[0];
wire b_chg = s2_q[1] ^ s3_q[1];
reg tick_d;
reg down_d;

always @(posedge clk or negedge rst_n) begin
	if (!rst_n) begin
		s1_q <= 3'h0;
		s2_q <= 3'h0;
		s3_q <= 3'h0;
	end else begin
		s1_q <= {pin_cap, pin_b, pin_a};
		s2_q <= s1_q;
		s3_q <= s2_q;
	end
end

// ----------------------------------------
// count event decode
// ----------------------------------------
// quadrature: direction from which phase moved against the other
always @* begin
	tick_d = 1'b0;
	down_d = 1'b0;
	case (cks)
	`TPUC_CKS_RISE: tick_d = a_rise;
	`TPUC_CKS_BOTH: tick_d = a_rise | a_fall;
	`TPUC_CKS_PHASE: begin
		tick_d = a_chg ^ b_chg;
		down_d = a_chg ? (a_now == b_now) : (a_now != b_now);
	end
	default: tick_d = 1'b0;
	endcase
end

always @(posedge clk or negedge rst_n) begin
	if (!rst_n) begin
		tick_q <= 1'b0;
		down_q <= 1'b0;
		cap_q <= 1'b0;
	end else begin
		tick_q <= tick_d;
		down_q <= down_d;
		cap_q <= s2_q[2] & ~s3_q[2];
	end
end

endmodule

// ---- tpuc_props.sv ----
// Purpose: port checker for tpuc_timer
// Assumes: enables are shadowed from APB writes to CTRL
// Notes: request and pin outputs lag their cause by one edge
`timescale 1ns/1ps
`include "tpuc_consts.vh"
module tpuc_props (
	// clock and reset
	input logic ref_clk,
	input logic rstn,
	// apb
	input logic psel,
	input logic penable,
	input logic pwrite,
	input logic [31:0] paddr,
	input logic [31:0] pwdata,
	input logic [31:0] prdata,
	input logic pready,
	input logic pslverr,
	// pins and requests
	input logic match_out,
	input logic match_irq,
	input logic ovf_irq,
	input logic unf_irq,
	input logic xfer_req,
	input logic xfer_ack
);
	logic [12:0] ctl_q;
	logic bad;
	default clocking @(posedge ref_clk); endclocking
	default disable iff (!rstn);
	// shadow copy, so gating can be judged from the ports alone
	always_ff @(posedge ref_clk or negedge rstn) begin
		if (!rstn)
			ctl_q <= 13'h0000;
		else if (psel && penable && pwrite && paddr == `TPUC_OFS_CTRL)
			ctl_q <= pwdata[12:0];
	end
	assign bad = paddr > 32'h10 || paddr[1:0] != 2'h0;
	sequence s_acc;
		psel && penable;
	endsequence
	sequence s_rd;
		psel && penable && !pwrite;
	endsequence
	a_ready_access: assert property (s_acc |-> pready)
		else $error("pready low in access");
	a_bad_addr_err: assert property (s_acc ##0 bad |-> pslverr)
		else $error("no error on bad address");
	a_good_addr_ok: assert property (s_acc ##0 !bad |-> !pslverr)
		else $error("error on good address");
	a_upper_zero: assert property (s_rd |-> prdata[31:16] == 16'h0000)
		else $error("upper read bits set");
	a_match_gate: assert property (
		!$past(ctl_q[`TPUC_C_MIE]) && !$past(ctl_q[`TPUC_C_STOP])
		|-> !match_irq) else $error("match request while disabled");
	a_ovf_gate: assert property (
		!$past(ctl_q[`TPUC_C_VIE]) && !$past(ctl_q[`TPUC_C_STOP])
		|-> !ovf_irq) else $error("overflow request while disabled");
	a_unf_gate: assert property (
		!$past(ctl_q[`TPUC_C_UIE]) && !$past(ctl_q[`TPUC_C_STOP])
		|-> !unf_irq) else $error("underflow request while disabled");
	a_xfer_gate: assert property (
		!$past(ctl_q[`TPUC_C_XFEN]) && !$past(ctl_q[`TPUC_C_STOP])
		|-> !xfer_req) else $error("transfer request while disabled");
	a_stop_freeze: assert property (
		ctl_q[`TPUC_C_STOP] && $past(ctl_q[`TPUC_C_STOP], 2)
		|-> $stable({match_irq, ovf_irq, unf_irq, xfer_req}))
		else $error("request moved in module stop");
	a_ack_drops: assert property (
		xfer_ack && !ctl_q[`TPUC_C_STOP] && !ctl_q[`TPUC_C_RUN]
		|-> ##[1:3] !xfer_req) else $error("request kept after ack");
	a_oe_quiet: assert property (
		!$past(ctl_q[`TPUC_C_OE]) && !$past(ctl_q[`TPUC_C_STOP])
		|-> !match_out)
		else $error("compare output high while disabled");
endmodule
bind tpuc_timer tpuc_props i_props (.ref_clk, .rstn, .psel, .penable,
	.pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .match_out,
	.match_irq, .ovf_irq, .unf_irq, .xfer_req, .xfer_ack);

// ---- tpuc_timer.v ----
// Purpose: timer channel with CPU-versus-event contention resolution
// Assumes: APB master, asynchronous pins synchronised by tpuc_edge
// Notes: APB setup cycle is the first state, access the final state
`timescale 1ns/1ps
`include "tpuc_consts.vh"

module tpuc_timer #(
	parameter DIV = 8
) (
	// clock and reset
	input wire ref_clk,
	input wire rstn,
	// apb slave
	input wire psel,
	input wire penable,
	input wire pwrite,
	input wire [31:0] paddr,
	input wire [31:0] pwdata,
	output reg [31:0] prdata,
	output reg pready,
	output reg pslverr,
	// timer pins
	input wire clk_in_a,
	input wire clk_in_b,
	input wire capture_in,
	output reg match_out,
	// requests
	output reg match_irq,
	output reg ovf_irq,
	output reg unf_irq,
	output reg xfer_req,
	input wire xfer_ack
);

// ----------------------------------------
// reset release
// ----------------------------------------
reg [1:0] rst_sync_q;
wire rst_n = rst_sync_q[1];

always @(posedge ref_clk or negedge rstn) begin
	if (!rstn)
		rst_sync_q <= 2'h0;
	else
		rst_sync_q <= {rst_sync_q[0], 1'b1};
end

// ----------------------------------------
// state
// ----------------------------------------
reg [`TPUC_CTRL_W-1:0] ctrl_q;
reg [15:0] cnt_q;
reg [15:0] cnt_d;
reg [15:0] match_q;
reg [15:0] match_d;
reg [15:0] buf_q;
reg [15:0] buf_d;
reg mcf_q;
reg mcf_d;
reg ovf_q;
reg ovf_d;
reg unf_q;
reg unf_d;
reg dir_q;
reg [2:0] seen_one_q;
reg [15:0] pre_q;
reg pre_tick_q;

wire run = ctrl_q[`TPUC_C_RUN];
wire [1:0] cks = ctrl_q[`TPUC_C_CKS_HI:`TPUC_C_CKS_LO];
wire [1:0] clr_sel = ctrl_q[`TPUC_C_CLR_HI:`TPUC_C_CLR_LO];
wire capt_mode = ctrl_q[`TPUC_C_CAPT];
wire buf_en = ctrl_q[`TPUC_C_BUFEN];
wire stopped = ctrl_q[`TPUC_C_STOP];

// ----------------------------------------
// bus access phases
// ----------------------------------------
wire setup = psel & ~penable;
wire fin = psel & penable;
wire wr_fin = fin & pwrite;
wire [4:0] ofs = paddr[4:0];
wire hit_ctrl = ofs == `TPUC_OFS_CTRL;
wire hit_stat = ofs == `TPUC_OFS_STAT;
wire hit_cnt = ofs == `TPUC_OFS_CNT;
wire hit_match = ofs == `TPUC_OFS_MATCH;
wire hit_buf = ofs == `TPUC_OFS_BUF;
wire mapped = (paddr[31:5] == 27'h0000000) & (paddr[1:0] == 2'h0) &
	(hit_ctrl | hit_stat | hit_cnt | hit_match | hit_buf);
// collisions only in the final state of a write
wire wr_cnt = wr_fin & mapped & hit_cnt & ~stopped;
wire wr_match = wr_fin & mapped & hit_match & ~stopped;
wire wr_buf = wr_fin & mapped & hit_buf & ~stopped;
wire wr_stat = wr_fin & mapped & hit_stat & ~stopped;
wire wr_ctrl = wr_fin & mapped & hit_ctrl;
wire rd_stat = fin & ~pwrite & mapped & hit_stat;

// ----------------------------------------
// count sources
// ----------------------------------------
wire ext_tick;
wire ext_down;
wire cap_pulse;

tpuc_edge u_edge (
	.clk(ref_clk),
	.rst_n(rst_n),
	.cks(cks),
	.pin_a(clk_in_a),
	.pin_b(clk_in_b),
	.pin_cap(capture_in),
	.tick_q(ext_tick),
	.down_q(ext_down),
	.cap_q(cap_pulse)
);

// internal count clock is a divided enable pulse
// divider free-runs; run and stop gate its tick, not the divider itself
always @(posedge ref_clk or negedge rst_n) begin
	if (!rst_n) begin
		pre_q <= 16'h0000;
		pre_tick_q <= 1'b0;
	end else if (pre_q == DIV[15:0] - 16'h0001) begin
		pre_q <= 16'h0000;
		pre_tick_q <= 1'b1;
	end else begin
		pre_q <= pre_q + 16'h0001;
		pre_tick_q <= 1'b0;
	end
end

wire active = run & ~stopped;
wire tick = active & ((cks == `TPUC_CKS_INT) ? pre_tick_q : ext_tick);
wire down = (cks == `TPUC_CKS_PHASE) & ext_down;

// ----------------------------------------
// events
// ----------------------------------------
// match only at the count update point, so once per input clock
wire match_raw = tick & ~capt_mode & (cnt_q == match_q);
wire match_ev = match_raw & ~wr_match;
wire cap_ev = active & capt_mode & cap_pulse;
wire clr_ev = ((clr_sel == `TPUC_CLR_MATCH) & match_ev) |
	((clr_sel == `TPUC_CLR_CAPT) & cap_ev);
wire wrap_up = tick & ~down & (cnt_q == 16'hFFFF);
wire wrap_dn = tick & down & (cnt_q == 16'h0000);
wire xfer_clr = xfer_ack & ctrl_q[`TPUC_C_XFEN] & ~stopped;

// ----------------------------------------
// counter and data registers
// ----------------------------------------
// clear beats a write, a write beats a count
always @* begin
	cnt_d = cnt_q;
	if (clr_ev)
		cnt_d = `TPUC_CNT_RST;
	else if (wr_cnt)
		cnt_d = pwdata[15:0];
	else if (tick && down)
		cnt_d = cnt_q - 16'h0001;
	else if (tick)
		cnt_d = cnt_q + 16'h0001;
end

// capture owns both registers in its cycle, so a write is lost
always @* begin
	match_d = match_q;
	buf_d = buf_q;
	if (cap_ev) begin
		match_d = cnt_q;
		if (buf_en)
			buf_d = match_q;
	end else begin
		if (wr_match)
			match_d = pwdata[15:0];
		else if (match_ev && buf_en)
			match_d = buf_q;
		if (wr_buf)
			buf_d = pwdata[15:0];
	end
end

// ----------------------------------------
// status flags
// ----------------------------------------
// set wins over any clear; stopped freezes clearing
always @* begin
	mcf_d = mcf_q;
	ovf_d = ovf_q;
	unf_d = unf_q;
	if (wr_stat && seen_one_q[`TPUC_S_MCF] && !pwdata[`TPUC_S_MCF])
		mcf_d = 1'b0;
	if (xfer_clr)
		mcf_d = 1'b0;
	if (wr_stat && seen_one_q[`TPUC_S_OVF] && !pwdata[`TPUC_S_OVF])
		ovf_d = 1'b0;
	if (wr_stat && seen_one_q[`TPUC_S_UNF] && !pwdata[`TPUC_S_UNF])
		unf_d = 1'b0;
	if (match_ev || cap_ev)
		mcf_d = 1'b1;
	if (wrap_up && !clr_ev && !wr_cnt)
		ovf_d = 1'b1;
	if (wrap_dn && !clr_ev && !wr_cnt)
		unf_d = 1'b1;
end

// ----------------------------------------
// flag bookkeeping
// ----------------------------------------
// a flag clears by a write only after software has seen it set, so one that
// rose after the read survives the following write
wire [2:0] flag_now;
wire [2:0] flag_keep;

assign flag_now[`TPUC_S_MCF] = mcf_q;
assign flag_now[`TPUC_S_OVF] = ovf_q;
assign flag_now[`TPUC_S_UNF] = unf_q;
assign flag_keep[`TPUC_S_MCF] = pwdata[`TPUC_S_MCF];
assign flag_keep[`TPUC_S_OVF] = pwdata[`TPUC_S_OVF];
assign flag_keep[`TPUC_S_UNF] = pwdata[`TPUC_S_UNF];

always @(posedge ref_clk or negedge rst_n) begin
	if (!rst_n) begin
		cnt_q <= `TPUC_CNT_RST;
		match_q <= `TPUC_MATCH_RST;
		buf_q <= `TPUC_BUF_RST;
		mcf_q <= 1'b0;
		ovf_q <= 1'b0;
		unf_q <= 1'b0;
		dir_q <= 1'b0;
		seen_one_q <= 3'h0;
	end else begin
		cnt_q <= cnt_d;
		match_q <= match_d;
		buf_q <= buf_d;
		mcf_q <= mcf_d;
		ovf_q <= ovf_d;
		unf_q <= unf_d;
		if (tick)
			dir_q <= down;
		if (rd_stat)
			seen_one_q <= seen_one_q | flag_now;
		else if (wr_stat)
			seen_one_q <= seen_one_q & flag_keep;
	end
end

// ----------------------------------------
// control register
// ----------------------------------------
always @(posedge ref_clk or negedge rst_n) begin
	if (!rst_n)
		ctrl_q <= `TPUC_CTRL_RST;
	else if (wr_ctrl)
		ctrl_q <= pwdata[`TPUC_CTRL_W-1:0];
end

// ----------------------------------------
// apb answer
// ----------------------------------------
// read data, DIR and CTRL aside, taken from next-state values at the setup edge, so a
// capture in the first state is already visible
reg [31:0] rdata_d;

always @* begin
	rdata_d = 32'h00000000;
	case (ofs)
	`TPUC_OFS_CTRL: rdata_d[`TPUC_CTRL_W-1:0] = ctrl_q;
	`TPUC_OFS_STAT: begin
		rdata_d[`TPUC_S_MCF] = mcf_d;
		rdata_d[`TPUC_S_OVF] = ovf_d;
		rdata_d[`TPUC_S_UNF] = unf_d;
		rdata_d[`TPUC_S_DIR] = dir_q;
	end
	`TPUC_OFS_CNT: rdata_d[15:0] = cnt_d;
	`TPUC_OFS_MATCH: rdata_d[15:0] = match_d;
	`TPUC_OFS_BUF: rdata_d[15:0] = buf_d;
	default: rdata_d = 32'h00000000;
	endcase
	if (!mapped)
		rdata_d = 32'h00000000;
end

// no wait states: pready stays high from reset release on
always @(posedge ref_clk or negedge rst_n) begin
	if (!rst_n) begin
		prdata <= 32'h00000000;
		pready <= 1'b0;
		pslverr <= 1'b0;
	end else begin
		pready <= 1'b1;
		if (setup) begin
			prdata <= pwrite ? 32'h00000000 : rdata_d;
			pslverr <= ~mapped;
		end
	end
end

// ----------------------------------------
// requests and compare output
// ----------------------------------------
// stop freezes the lines as they stood
// the ack drops the transfer line in the cycle it clears the flag
always @(posedge ref_clk or negedge rst_n) begin
	if (!rst_n) begin
		match_irq <= 1'b0;
		ovf_irq <= 1'b0;
		unf_irq <= 1'b0;
		xfer_req <= 1'b0;
		match_out <= 1'b0;
	end else if (!stopped) begin
		match_irq <= mcf_d & ctrl_q[`TPUC_C_MIE];
		ovf_irq <= ovf_d & ctrl_q[`TPUC_C_VIE];
		unf_irq <= unf_d & ctrl_q[`TPUC_C_UIE];
		xfer_req <= mcf_d & ctrl_q[`TPUC_C_XFEN] & ~xfer_clr;
		if (!ctrl_q[`TPUC_C_OE])
			match_out <= 1'b0;
		else if (match_ev)
			match_out <= ~match_out;
	end
end

endmodule

// ---- tpuc_timer_test.sv ----
// Purpose: self-checking bench for tpuc_timer
// Assumes: DIV of 1, so the internal clock counts every cycle
// Notes: the overflow run takes most of the time
`timescale 1ns/1ps
`include "tpuc_consts.vh"
module tpuc_timer_test;
	logic ref_clk = 0, rstn = 0, psel = 0, penable = 0, pwrite = 0;
	logic [31:0] paddr = 0, pwdata = 0, prdata, rv;
	logic pready, pslverr, match_out, match_irq, ovf_irq, unf_irq;
	logic clk_in_a = 0, xfer_req, xfer_ack, ack_en = 0, err;
	logic clk_in_b = 0, capture_in = 0;
	logic ovf_seen = 0;
	int n_errors = 0, check_count = 0, n;
	tpuc_timer #(.DIV(1)) i_dut (.ref_clk, .rstn, .psel, .penable,
		.pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .clk_in_a,
		.clk_in_b, .capture_in, .match_out, .match_irq,
		.ovf_irq, .unf_irq, .xfer_req, .xfer_ack);
	tpuc_xfer_model i_xfer (.ref_clk, .rstn, .en(ack_en), .lat(4'h2),
		.xfer_req, .xfer_ack);
	initial forever #10 ref_clk = ~ref_clk;
	always @(posedge ref_clk) if (ovf_irq === 1'b1) ovf_seen <= 1'b1;
	task automatic end_sim;
		if (n_errors == 0 && check_count > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask
	task automatic chk(input string nm, input logic [31:0] seen, exp);
		check_count++;
		if (seen !== exp) begin
			$display("Error %s expected %h seen %h", nm, exp, seen);
			n_errors++;
		end
	endtask
	task automatic apb(input logic w, input logic [31:0] a, d);
		int k;
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge ref_clk);
		penable <= 1'b1;
		k = 0;
		do begin
			@(posedge ref_clk);
			k++;
		end while (pready !== 1'b1 && k < 16);
		if (pready !== 1'b1) begin
			chk("pready", pready, 1);
			end_sim;
		end
		rv = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge ref_clk);
	endtask
	task automatic wr(input logic [31:0] a, d);
		apb(1'b1, a, d);
	endtask
	task automatic rd(input logic [31:0] a, exp);
		apb(1'b0, a, 32'h0);
		chk($sformatf("reg %0h", a), rv, exp);
	endtask
	// pulses stay w cycles wide and w cycles apart
	task automatic pulse(input int k, w);
		repeat (k) begin
			clk_in_a <= 1'b1;
			repeat (w) @(posedge ref_clk);
			clk_in_a <= 1'b0;
			repeat (w) @(posedge ref_clk);
		end
		repeat (4) @(posedge ref_clk);
	endtask
	// quadrature steps three cycles apart; dn lets phase b lead
	task automatic quad(input int k, input bit dn);
		logic [1:0] ph;
		ph = {clk_in_b, clk_in_a};
		repeat (4 * k) begin
			ph = dn ? {~ph[0], ph[1]} : {ph[0], ~ph[1]};
			{clk_in_b, clk_in_a} <= ph;
			repeat (3) @(posedge ref_clk);
		end
		repeat (4) @(posedge ref_clk);
	endtask
	task automatic gap(output int c);
		logic o;
		o = match_out;
		c = 0;
		do begin
			@(posedge ref_clk);
			c++;
		end while (match_out === o && c < 100);
		if (match_out === o) begin
			chk("match_out", 0, 1);
			end_sim;
		end
	endtask
	initial begin
		repeat (16) @(posedge ref_clk);
		rstn <= 1'b1;
		repeat (4) @(posedge ref_clk);
		rd(`TPUC_OFS_CTRL, 0);
		rd(`TPUC_OFS_MATCH, 32'hFFFF);
		rd(`TPUC_OFS_BUF, 32'hFFFF);
		rd(`TPUC_OFS_CNT, 0);
		rd(32'h14, 0);
		chk("pslverr", err, 1);
		wr(`TPUC_OFS_CTRL, 32'h3);
		pulse(5, 2);
		rd(`TPUC_OFS_CNT, 5);
		wr(`TPUC_OFS_CTRL, 32'h5);
		pulse(5, 3);
		rd(`TPUC_OFS_CNT, 15);
		wr(`TPUC_OFS_CTRL, 32'h7);
		quad(2, 0);
		rd(`TPUC_OFS_CNT, 23);
		quad(2, 1);
		rd(`TPUC_OFS_CNT, 15);
		rd(`TPUC_OFS_STAT, 32'h8);
		wr(`TPUC_OFS_CTRL, 32'h63);
		wr(`TPUC_OFS_CNT, 32'h1234);
		wr(`TPUC_OFS_MATCH, 32'hAA);
		wr(`TPUC_OFS_BUF, 32'hBB);
		capture_in <= 1'b1;
		repeat (2) @(posedge ref_clk);
		wr(`TPUC_OFS_MATCH, 32'h5555);
		capture_in <= 1'b0;
		rd(`TPUC_OFS_MATCH, 32'h1234);
		rd(`TPUC_OFS_BUF, 32'hAA);
		capture_in <= 1'b1;
		repeat (2) @(posedge ref_clk);
		wr(`TPUC_OFS_BUF, 32'h6666);
		capture_in <= 1'b0;
		rd(`TPUC_OFS_BUF, 32'h1234);
		wr(`TPUC_OFS_CNT, 32'h4321);
		capture_in <= 1'b1;
		repeat (3) @(posedge ref_clk);
		rd(`TPUC_OFS_MATCH, 32'h4321);
		capture_in <= 1'b0;
		wr(`TPUC_OFS_CNT, 0);
		wr(`TPUC_OFS_MATCH, 4);
		wr(`TPUC_OFS_CTRL, 32'h1489);
		gap(n);
		gap(n);
		chk("period", n, 5);
		wr(`TPUC_OFS_CTRL, 32'h1488);
		chk("match_irq", match_irq, 1);
		rd(`TPUC_OFS_STAT, 1);
		wr(`TPUC_OFS_STAT, 0);
		repeat (3) @(posedge ref_clk);
		chk("match_irq", match_irq, 0);
		wr(`TPUC_OFS_CTRL, 32'h1489);
		repeat (8) @(posedge ref_clk);
		wr(`TPUC_OFS_CTRL, 32'h1488);
		ack_en <= 1'b1;
		repeat (8) @(posedge ref_clk);
		rd(`TPUC_OFS_STAT, 0);
		chk("xfer_req", xfer_req, 0);
		ack_en <= 1'b0;
		wr(`TPUC_OFS_CTRL, 32'h1489);
		repeat (8) @(posedge ref_clk);
		wr(`TPUC_OFS_CTRL, 32'h1488);
		rd(`TPUC_OFS_STAT, 1);
		wr(`TPUC_OFS_CTRL, 32'h1C88);
		wr(`TPUC_OFS_STAT, 0);
		rd(`TPUC_OFS_STAT, 1);
		chk("match_irq", match_irq, 1);
		wr(`TPUC_OFS_CTRL, 32'h1488);
		rd(`TPUC_OFS_STAT, 1);
		wr(`TPUC_OFS_STAT, 0);
		rd(`TPUC_OFS_STAT, 0);
		wr(`TPUC_OFS_CTRL, 0);
		wr(`TPUC_OFS_MATCH, 32'hFFFF);
		wr(`TPUC_OFS_CNT, 0);
		wr(`TPUC_OFS_CTRL, 32'h109);
		repeat (66000) @(posedge ref_clk);
		wr(`TPUC_OFS_CTRL, 32'h108);
		rd(`TPUC_OFS_STAT, 1);
		chk("ovf_irq", ovf_seen, 0);
		wr(`TPUC_OFS_CTRL, 32'h80);
		repeat (2) @(posedge ref_clk);
		chk("match_irq", match_irq, 1);
		wr(`TPUC_OFS_CTRL, 0);
		wr(`TPUC_OFS_CTRL, 32'h800);
		chk("match_irq", match_irq, 0);
		end_sim;
	end
endmodule

// ---- tpuc_xfer_model.sv ----
// Purpose: transfer controller stand-in serving match requests
// Assumes: xfer_ack is a one-cycle pulse
// Notes: lat sets how slowly a request is served
`timescale 1ns/1ps
module tpuc_xfer_model (
	// clock and reset
	input logic ref_clk,
	input logic rstn,
	// control from the bench
	input logic en,
	input logic [3:0] lat,
	// request and answer
	input logic xfer_req,
	output logic xfer_ack
);
	logic [3:0] wait_q;
	logic done_q;
	// one service per request; waits for the drop before serving again
	always_ff @(posedge ref_clk or negedge rstn) begin
		if (!rstn) begin
			wait_q <= 4'h0;
			done_q <= 1'b0;
			xfer_ack <= 1'b0;
		end else begin
			xfer_ack <= 1'b0;
			if (!xfer_req) begin
				wait_q <= 4'h0;
				done_q <= 1'b0;
			end else if (en && !done_q) begin
				if (wait_q == lat) begin
					xfer_ack <= 1'b1;
					done_q <= 1'b1;
				end else
					wait_q <= wait_q + 4'h1;
			end
		end
	end
endmodule
